// *** hdl/asf_pkg.sv ***
package asf_pkg;

  // sizes of the frame and of the fields in it
  localparam int unsigned ASF_NUM_CH    = 8;
  localparam int unsigned ASF_WORD_BITS = 16;
  localparam int unsigned ASF_CODE_BITS = 12;

  // ahb byte offsets; the eight level words sit at 0x00..0x1c
  localparam logic [7:0] ASF_OFF_LEVEL0 = 8'h00;
  localparam logic [7:0] ASF_OFF_CFG    = 8'h20;
  localparam logic [7:0] ASF_OFF_STATUS = 8'h24;
  localparam logic [7:0] ASF_OFF_RESULT = 8'h28;

  // falling-edge counts inside a frame
  localparam logic [4:0] ASF_CNT_LOAD = 5'h0b;
  localparam logic [4:0] ASF_CNT_LAST = 5'h0f;
  localparam logic [4:0] ASF_CNT_DONE = 5'h10;

  // control word bit positions
  localparam int ASF_WRITE_BIT           = 11;
  localparam int ASF_SEQUENCE_ENABLE_BIT = 10;
  localparam int ASF_CHANNEL_SELECT_MSB  = 8;
  localparam int ASF_CHANNEL_SELECT_LSB  = 6;
  localparam int ASF_SHADOW_BIT          = 3;
  localparam int ASF_RANGE_BIT           = 1;
  localparam int ASF_CODING_BIT          = 0;

  // reset values and codes
  localparam logic [11:0] ASF_CTRL_RST  = 12'h000;
  localparam logic [1:0]  ASF_CFG_RST   = 2'h0;
  localparam logic [1:0]  ASF_RES_12    = 2'h0;
  localparam logic [1:0]  ASF_RES_10    = 2'h1;
  localparam logic [1:0]  ASF_RES_8     = 2'h2;
  localparam logic [11:0] ASF_TC_FLIP   = 12'h800;
  localparam logic [11:0] ASF_CODE_FULL = 12'hfff;

  // channel field of a control word
  function automatic logic [2:0] asf_chan(input logic [11:0] ctrl);
    return ctrl[ASF_CHANNEL_SELECT_MSB:ASF_CHANNEL_SELECT_LSB];
  endfunction

  // level is a fraction of twice the reference; narrow span doubles and clips
  function automatic logic [11:0] asf_code(input logic [11:0] lvl,
                                           input logic        wide,
                                           input logic        twos,
                                           input logic [1:0]  res);
    logic [11:0] c;
    c = wide ? lvl : (lvl[11] ? ASF_CODE_FULL : {lvl[10:0], 1'b0});
    if (twos)
      c = c ^ ASF_TC_FLIP;
    case (res)
      ASF_RES_10: c = {c[11:2], 2'h0};
      ASF_RES_8:  c = {c[11:4], 4'h0};
      default:    c = c;
    endcase
    return c;
  endfunction

endpackage

// *** hdl/asf_link.sv ***
`timescale 1ns/1ps
module asf_link
  import asf_pkg::*;
(
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  input  wire logic        hresetn,
  input  wire logic [15:0] pub_word,
  input  wire logic        pub_tgl,
  output logic             dout,
  output logic [11:0]      ctrl_word,
  output logic             frame_tgl
);

  // state that lives for one frame only
  typedef struct packed {
    logic [4:0]  cnt;
    logic [15:0] cur;
    logic [10:0] sr;
    logic        dout;
  } asf_frame_s;

  // state that outlives the frame
  typedef struct packed {
    logic [11:0] ctrl;
    logic        frame_tgl;
    logic [1:0]  psync;
    logic        pub_seen;
    logic [15:0] hold;
  } asf_keep_s;

  asf_frame_s fr_r;
  asf_frame_s fr_nxt;
  asf_keep_s  kp_r;
  asf_keep_s  kp_nxt;

  // all work is on falling shift-clock edges
  always_comb
  begin
    fr_nxt = fr_r;
    kp_nxt = kp_r;
    // a published word is taken only after its toggle has settled
    kp_nxt.psync = {kp_r.psync[0], pub_tgl};
    if (kp_r.psync[1] != kp_r.pub_seen)
    begin
      kp_nxt.pub_seen = kp_r.psync[1];
      kp_nxt.hold     = pub_word;
    end
    if (fr_r.cnt != ASF_CNT_DONE)
      fr_nxt.cnt = fr_r.cnt + 5'h01;
    // frame word frozen on the first edge, sent msb first
    if (fr_r.cnt == 5'h00)
    begin
      fr_nxt.cur  = kp_r.hold;
      fr_nxt.dout = kp_r.hold[14];
    end
    else if (fr_r.cnt < ASF_CNT_LAST)
      fr_nxt.dout = fr_r.cur[4'(5'h0e - fr_r.cnt)];
    else
      fr_nxt.dout = 1'b0; // fixed 16-bit word, tail reads zero
    // first twelve edges carry the control word
    if (fr_r.cnt < ASF_CNT_LOAD)
      fr_nxt.sr = {fr_r.sr[9:0], din};
    if (fr_r.cnt == ASF_CNT_LOAD && fr_r.sr[10])
      kp_nxt.ctrl = {fr_r.sr, din};
    // sixteenth edge closes the transfer
    if (fr_r.cnt == ASF_CNT_LAST)
      kp_nxt.frame_tgl = ~kp_r.frame_tgl;
  end

  // high frame select ends the frame without needing a clock edge
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
      fr_r <= '0;
    else
      fr_r <= fr_nxt;
  end

  always_ff @(negedge sclk or negedge hresetn)
  begin
    if (!hresetn)
      kp_r <= '{ctrl: ASF_CTRL_RST, default: '0};
    else
      kp_r <= kp_nxt;
  end

  assign dout      = fr_r.dout;
  assign ctrl_word = kp_r.ctrl;
  assign frame_tgl = kp_r.frame_tgl;

  sequence s_load_word;
    fr_r.cnt == ASF_CNT_LOAD && fr_r.sr[10];
  endsequence

  sequence s_last_edge;
    fr_r.cnt == ASF_CNT_LAST;
  endsequence

  a_dout_bit_order: assert property (@(negedge sclk) disable iff (cs_n || !hresetn)
    (fr_r.cnt >= 5'h02 && fr_r.cnt <= ASF_CNT_LAST)
    |-> dout == fr_r.cur[4'(5'h0f - fr_r.cnt)])
    else $error("serial bit out of order");

  a_lead_zero_chan: assert property (@(negedge sclk) disable iff (cs_n || !hresetn)
    fr_r.cnt == 5'h01 |-> !fr_r.cur[15] && dout == fr_r.cur[14])
    else $error("word does not open with zero and channel");

  a_ctrl_capture: assert property (@(negedge sclk) disable iff (cs_n || !hresetn)
    s_load_word |=> ctrl_word == {$past(fr_r.sr), $past(din)})
    else $error("control word not loaded");

  a_ctrl_keep: assert property (@(negedge sclk) disable iff (cs_n || !hresetn)
    (fr_r.cnt == ASF_CNT_LOAD && !fr_r.sr[10]) |=> $stable(ctrl_word))
    else $error("control word changed without write bit");

  a_word_length: assert property (@(negedge sclk) disable iff (cs_n || !hresetn)
    s_last_edge |=> !dout && frame_tgl != $past(frame_tgl))
    else $error("frame not closed after sixteen edges");

  a_frame_start: assert property (@(negedge sclk) disable iff (cs_n || !hresetn)
    fr_r.cnt == 5'h01 |-> fr_r.cur == $past(kp_r.hold))
    else $error("frame word not frozen at first edge");

endmodule // asf_link

// *** hdl/asf_top.sv ***
`timescale 1ns/1ps
// How it works
// - the selected channel index drives the track-and-hold input multiplexer.
// - channel select, sequence enable and shadow bits steer the channel sequencer.
// - one range bit picks span zero to reference or twice reference.
// - serial output moves to next bit on each falling shift edge, msb first.
// - each word opens with one zero then three channel number bits.
// - twelve-bit variant sends twelve result bits and no padding.
// - ten-bit variant sends ten result bits then two zeros.
// - eight-bit variant sends eight result bits then four zeros.
// - one coding bit picks straight binary or twos complement results.
// - host writes control on data-in, captured on falling shift edges.
// - frame select falling frames the transfer; the result is converted when the frame-end toggle is seen.
// - every transfer lasts sixteen shift edges, control in while result out.
module asf_top
  import asf_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        din,
  output logic             dout,
  output logic [2:0]       mux_sel,
  output logic             range_2x
);

  typedef struct packed {
    logic [ASF_NUM_CH-1:0][11:0] analog_input_channels;
    logic [1:0]                  res;
    logic [11:0]                 ctrl;
    logic [2:0]                  ch;
    logic [15:0]                 pub_word;
    logic                        pub_tgl;
    logic [2:0]                  fsync;
    logic                        init_done;
    logic [15:0]                 frames;
    logic                        wr_pend;
    logic [7:0]                  wr_addr;
    logic [31:0]                 hrdata;
  } asf_top_s;

  asf_top_s    st_r;
  asf_top_s    st_nxt;
  logic        frame_ev;
  logic        pub_ev;
  logic        addr_ok;
  logic [11:0] sel_lvl;
  logic [11:0] ctrl_word;
  logic        frame_tgl;

  // shift-clock side of the port
  asf_link u_link (
    .sclk      (sclk),
    .cs_n      (cs_n),
    .din       (din),
    .hresetn   (hresetn),
    .pub_word  (st_r.pub_word),
    .pub_tgl   (st_r.pub_tgl),
    .dout      (dout),
    .ctrl_word (ctrl_word),
    .frame_tgl (frame_tgl)
  );

  // bus, sequencer and result preparation
  always_comb
  begin
    st_nxt   = st_r;
    frame_ev = st_r.fsync[1] ^ st_r.fsync[2];
    pub_ev   = frame_ev || !st_r.init_done;
    addr_ok  = hsel && hready && htrans[1];
    sel_lvl  = 12'h000;

    // frame-end toggle through two flops; edge seen past the second
    st_nxt.fsync = {st_r.fsync[1:0], frame_tgl};

    // ctrl_word last moved four shift edges before the toggle, so it is settled
    if (frame_ev)
    begin
      st_nxt.ctrl   = ctrl_word;
      st_nxt.frames = st_r.frames + 16'h0001;
      if (ctrl_word[ASF_SHADOW_BIT] && !ctrl_word[ASF_SEQUENCE_ENABLE_BIT])
        st_nxt.ch = st_r.ch; // shadow access frame leaves the channel alone
      else if (!ctrl_word[ASF_SEQUENCE_ENABLE_BIT])
        st_nxt.ch = asf_chan(ctrl_word);
      else if (st_r.ch >= asf_chan(ctrl_word))
        st_nxt.ch = 3'h0; // sequence wraps to channel 0 after the channel in the select field
      else
        st_nxt.ch = st_r.ch + 3'h1;
    end

    // publish once per frame so the word is still while the link takes it
    sel_lvl = st_r.analog_input_channels[st_nxt.ch]; // track-and-hold input
    if (pub_ev)
    begin
      st_nxt.init_done = 1'b1;
      st_nxt.pub_tgl   = ~st_r.pub_tgl;
      st_nxt.pub_word  = {1'b0, st_nxt.ch,
                          asf_code(sel_lvl,
                                   st_nxt.ctrl[ASF_RANGE_BIT],
                                   st_nxt.ctrl[ASF_CODING_BIT],
                                   st_r.res)};
    end

    // write data phase
    if (st_r.wr_pend)
    begin
      st_nxt.wr_pend = 1'b0;
      if (st_r.wr_addr[7:5] == ASF_OFF_LEVEL0[7:5])
        st_nxt.analog_input_channels[st_r.wr_addr[4:2]] = hwdata[11:0];
      else if (st_r.wr_addr == ASF_OFF_CFG)
        st_nxt.res = hwdata[1:0];
    end

    // address phase; read data is registered for the data phase
    if (addr_ok)
    begin
      st_nxt.wr_pend = hwrite;
      st_nxt.wr_addr = {haddr[7:2], 2'h0};
      st_nxt.hrdata  = 32'h0000_0000;
      if (!hwrite)
      begin
        if (haddr[31:8] != 24'h00_0000)
          st_nxt.hrdata = 32'h0000_0000; // unmapped reads zero
        else if (haddr[7:5] == ASF_OFF_LEVEL0[7:5])
          st_nxt.hrdata = {20'h0_0000, st_r.analog_input_channels[haddr[4:2]]};
        else if (haddr[7:2] == ASF_OFF_CFG[7:2])
          st_nxt.hrdata = {30'h0000_0000, st_r.res};
        else if (haddr[7:2] == ASF_OFF_STATUS[7:2])
          st_nxt.hrdata = {st_r.frames, 1'b0, st_r.ch, st_r.ctrl};
        else if (haddr[7:2] == ASF_OFF_RESULT[7:2])
          st_nxt.hrdata = {16'h0000, st_r.pub_word};
      end
      if (haddr[31:8] != 24'h00_0000)
        st_nxt.wr_pend = 1'b0; // unmapped writes dropped
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_r <= '{ctrl: ASF_CTRL_RST, res: ASF_CFG_RST, default: '0};
    else
      st_r <= st_nxt;
  end

  // zero-wait slave, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_r.hrdata;
  assign mux_sel   = st_r.ch;
  assign range_2x  = st_r.ctrl[ASF_RANGE_BIT];

  sequence s_fixed_frame;
    frame_ev && !ctrl_word[ASF_SEQUENCE_ENABLE_BIT] && !ctrl_word[ASF_SHADOW_BIT];
  endsequence

  sequence s_sequencer_frame;
    frame_ev && ctrl_word[ASF_SEQUENCE_ENABLE_BIT];
  endsequence

  sequence s_plain_pub;
    pub_ev && st_r.res == ASF_RES_12;
  endsequence

  a_mux_fixed_chan: assert property (@(posedge hclk) disable iff (!hresetn)
    s_fixed_frame |=> mux_sel == asf_chan($past(ctrl_word)))
    else $error("mux not on selected channel");

  a_sequencer_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
    s_sequencer_frame ##0 (st_r.ch >= asf_chan(ctrl_word)) |=> st_r.ch == 3'h0)
    else $error("sequencer did not wrap");

  a_sequencer_step: assert property (@(posedge hclk) disable iff (!hresetn)
    s_sequencer_frame ##0 (st_r.ch < asf_chan(ctrl_word))
    |=> st_r.ch == $past(st_r.ch) + 3'h1)
    else $error("sequencer did not step");

  a_range_clip: assert property (@(posedge hclk) disable iff (!hresetn)
    s_plain_pub ##0 (!st_nxt.ctrl[ASF_RANGE_BIT] && !st_nxt.ctrl[ASF_CODING_BIT]
    && sel_lvl[11]) |=> st_r.pub_word[11:0] == ASF_CODE_FULL)
    else $error("narrow span did not clip");

  a_twelve_no_pad: assert property (@(posedge hclk) disable iff (!hresetn)
    s_plain_pub ##0 (st_nxt.ctrl[ASF_RANGE_BIT] && !st_nxt.ctrl[ASF_CODING_BIT])
    |=> st_r.pub_word[11:0] == $past(sel_lvl) && !st_r.pub_word[15])
    else $error("twelve-bit word mismatch");

  a_ten_pad_two: assert property (@(posedge hclk) disable iff (!hresetn)
    (pub_ev && st_r.res == ASF_RES_10) |=> st_r.pub_word[1:0] == 2'h0)
    else $error("ten-bit padding not zero");

  a_eight_pad_four: assert property (@(posedge hclk) disable iff (!hresetn)
    (pub_ev && st_r.res == ASF_RES_8) |=> st_r.pub_word[3:0] == 4'h0)
    else $error("eight-bit padding not zero");

  a_coding_msb_flip: assert property (@(posedge hclk) disable iff (!hresetn)
    s_plain_pub ##0 (st_nxt.ctrl[ASF_RANGE_BIT] && st_nxt.ctrl[ASF_CODING_BIT])
    |=> st_r.pub_word[11] == !$past(sel_lvl[11]))
    else $error("twos complement msb wrong");

  a_chan_in_word: assert property (@(posedge hclk) disable iff (!hresetn)
    pub_ev |=> st_r.pub_word[14:12] == st_r.ch && st_r.pub_tgl != $past(st_r.pub_tgl))
    else $error("channel bits not in word");

endmodule // asf_top

// *** test/asf_host_model.sv ***
`timescale 1ns/1ps
module asf_host_model
(
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout
);
  // link clock rests high outside frames, 64 ns period inside
  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b0;
  end

  // one sixteen-edge transfer; gap sets prompt or slow frame start
  task automatic frame(input logic [11:0] ctl, input int gap, output logic [15:0] word);
    int i;
    #(gap);
    cs_n = 1'b0;
    din  = ctl[11];
    #32;
    word[15] = dout;
    for (i = 0; i < 16; i++)
    begin
      sclk = 1'b0;
      #32;
      sclk = 1'b1;
      if (i < 15)
        word[14-i] = dout;
      din = (i < 11) ? ctl[10-i] : ~din;
      #32;
    end
    cs_n = 1'b1;
    din  = ~din; // released line must not look stable
  endtask
endmodule // asf_host_model

// *** test/asf_top_tb.sv ***
`timescale 1ns/1ps
module asf_top_tb;
  import asf_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        sclk, cs_n, din, dout, range_2x;
  logic [2:0]  mux_sel;
  int          miscompares;
  int          samples_checked;
  logic [31:0] seed;
  logic [15:0] sent [$];
  logic [11:0] lvl [8];
  logic [11:0] corner [4] = '{12'hfff, 12'h800, 12'h7ff, 12'h000};
  logic [11:0] ctrl;
  logic [2:0]  ch;
  logic [1:0]  res;
  logic [15:0] frames;

  asf_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
               .hready(hreadyout), .hreadyout, .hresp, .hrdata, .sclk, .cs_n, .din,
               .dout, .mux_sel, .range_2x);
  asf_host_model host (.sclk, .cs_n, .din, .dout);

  // bus clock, 50 ns
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // narrow span doubles the level and clips at full scale
  function automatic logic [11:0] ecode(input logic [11:0] l, input logic wide,
                                        input logic twos, input logic [1:0] r);
    logic [11:0] c;
    c = wide ? l : (l[11] ? 12'hfff : {l[10:0], 1'b0});
    c[11] = c[11] ^ twos;
    if (r == ASF_RES_10)
      c[1:0] = 2'h0;
    if (r == ASF_RES_8)
      c[3:0] = 4'h0;
    return c;
  endfunction

  function automatic logic [2:0] next_ch(input logic [2:0] c, input logic [11:0] k);
    if (k[ASF_SEQUENCE_ENABLE_BIT])
      return (c >= k[8:6]) ? 3'h0 : c + 3'h1;
    if (k[ASF_SHADOW_BIT])
      return c;
    return k[8:6];
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // single word transfer; holds each phase until hready is sampled high
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog well beyond the ~110 us the frames need
  initial
  begin
    #1000000;
    miscompares++;
    complete_run();
  end

  // registers first, then random frames with corner levels early on
  initial
  begin
    logic [31:0] r;
    logic [15:0] w;
    logic [11:0] nctl;
    int k;
    hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; hresetn = 1'b0;
    miscompares = 0; samples_checked = 0; seed = 32'hf18c7a6f;
    ctrl = ASF_CTRL_RST; ch = 3'h0; frames = 16'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, ASF_OFF_STATUS, 32'h0, r);
    chk("status", r, 32'h0);
    ahb(1'b0, ASF_OFF_CFG, 32'h0, r);
    chk("cfg", r, {30'h0, ASF_CFG_RST});
    chk("mux_sel", {29'h0, mux_sel}, 32'h0);
    chk("range_2x", {31'h0, range_2x}, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    ahb(1'b1, 8'h30, 32'hffffffff, r);
    ahb(1'b0, 8'h30, 32'h0, r);
    chk("unmapped", r, 32'h0);
    ahb(1'b1, ASF_OFF_STATUS, 32'hffffffff, r);
    ahb(1'b0, ASF_OFF_STATUS, 32'h0, r);
    chk("status ro", r, 32'h0);
    for (k = 0; k < 8; k++)
    begin
      seed = lfsr(seed);
      lvl[k] = seed[11:0];
      ahb(1'b1, ASF_OFF_LEVEL0 + 8'(4 * k), {20'hfffff, lvl[k]}, r);
      ahb(1'b0, ASF_OFF_LEVEL0 + 8'(4 * k), 32'h0, r);
      chk("level", r, {20'h0, lvl[k]});
    end
    for (k = 0; k < 48; k++)
    begin
      seed = lfsr(seed);
      nctl = seed[11:0];
      nctl[ASF_WRITE_BIT] = (k % 7 != 3);
      res = k[1:0];
      ahb(1'b1, ASF_OFF_CFG, {30'h0, res}, r);
      if (nctl[ASF_WRITE_BIT])
        ctrl = nctl;
      ch = next_ch(ch, ctrl);
      lvl[ch] = (k < 8) ? corner[k[1:0]] : seed[23:12];
      ahb(1'b1, ASF_OFF_LEVEL0 + 8'(4 * ch), {20'h0, lvl[ch]}, r);
      sent.push_back({1'b0, ch, ecode(lvl[ch], ctrl[ASF_RANGE_BIT], ctrl[ASF_CODING_BIT], res)});
      host.frame(nctl, 40 + 8 * int'(seed[27:24]), w);
      frames++;
      if (k >= 2)
        chk("serial word", {16'h0, w}, {16'h0, sent[k-2]});
      repeat (10) @(posedge hclk);
      chk("idle dout", {31'h0, dout}, 32'h0);
      chk("mux_sel", {29'h0, mux_sel}, {29'h0, ch});
      chk("range_2x", {31'h0, range_2x}, {31'h0, ctrl[ASF_RANGE_BIT]});
      ahb(1'b0, ASF_OFF_STATUS, 32'h0, r);
      chk("status", r, {frames, 1'b0, ch, ctrl});
      ahb(1'b0, ASF_OFF_RESULT, 32'h0, r);
      chk("result", r, {16'h0, sent[k]});
    end
    complete_run();
  end
endmodule // asf_top_tb
